// ---- lss_pkg.sv ----
/*
 * lss_pkg: offsets, field positions and reset values of the L1 PM
 * substates and sideband configuration register bank.
 * Assumes a 12-bit configuration-space byte address with aligned dword access.
 */
package lss_pkg;

	// ==================================================================
	// register offsets (byte addresses in configuration space)
	localparam logic [11:0] OFS_CAP_HDR = 12'h240;
	localparam logic [11:0] OFS_CAP = 12'h244;
	localparam logic [11:0] OFS_CTL1 = 12'h248;
	localparam logic [11:0] OFS_CTL2 = 12'h24C;
	localparam logic [11:0] OFS_LINK_STATE = 12'h33C;
	localparam logic [11:0] OFS_HOT_LINK = 12'h340;
	localparam logic [11:0] OFS_SIDEBAND = 12'h344;
	localparam logic [11:0] OFS_CFC_EN = 12'h350;
	localparam logic [11:0] OFS_CFC_THR = 12'h354;

	// ==================================================================
	// capability header contents
	localparam logic [15:0] CAP_ID = 16'h001E;
	localparam logic [3:0] CAP_VER = 4'h1;
	localparam logic [11:0] CAP_NEXT = 12'h000;

	// ==================================================================
	// field positions
	localparam int CAP_PCI11_BIT = 1;
	localparam int CAP_ASPM11_BIT = 3;
	localparam int CAP_L1PM_BIT = 4;
	localparam int CTL_PCI11_BIT = 1;
	localparam int CTL_ASPM11_BIT = 3;
	localparam int SB_PROTO_BIT = 0;
	localparam int SB_ADDR_LSB = 1;
	localparam int SB_PEC_DIS_BIT = 9;
	localparam int SB_PEC_FAIL_BIT = 29;
	localparam int SB_UNSUP_BIT = 30;
	localparam int CFC_P1_BIT = 1;
	localparam int CFC_P2_BIT = 2;

	// ==================================================================
	// values after reset
	localparam logic RST_CAP_PCI11 = 1'b1;
	localparam logic RST_CAP_ASPM11 = 1'b0;
	localparam logic RST_CAP_L1PM = 1'b1;
	localparam logic RST_CTL = 1'b0;
	localparam logic [7:0] RST_LINK_STATE = 8'h00;
	localparam logic [15:0] RST_HOTPLUG = 16'h0000;
	localparam logic [15:0] RST_LINK_LAYER = 16'h0004;
	localparam logic RST_SB_PROTO = 1'b1;
	localparam logic [3:0] RST_SB_ADDR_HI = 4'hD;
	localparam logic [2:0] RST_SB_ADDR_LO = 3'h0;
	localparam logic RST_PEC_DIS = 1'b1;
	localparam logic [1:0] RST_CFC_EN = 2'h0;
	localparam logic [15:0] RST_THR_X1 = 16'h0080;
	localparam logic [15:0] RST_THR_X2 = 16'h0200;

	// number of sticky sideband error flags
	localparam int NUM_FLAGS = 2;

endpackage

// ---- lss_flag.sv ----
/*
 * lss_flag: one sticky status flag, set by a hardware event and
 * cleared by a write of one from software.
 * Assumes set and clr are synchronous single-cycle strobes on mclk.
 */
`timescale 1ns/1ps

module lss_flag (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic set,
	input wire logic clr,
	output logic flag_q
);

	// ==================================================================
	// sticky bit
	// set beats clear so an event landing on the clearing write survives
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= 1'b0; // cleared flag after reset
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end

endmodule

// ---- lss_regs.sv ----
/*
 * lss_regs: L1 PM substates capability, sideband control and completion
 * flow-control register bank, reached over a simple config access port.
 * Assumes cfg_req is a one-cycle strobe on mclk, preload and events come
 * from the sideband/EEPROM loader, and strap_addr is stable at reset release.
 */
`timescale 1ns/1ps

module lss_regs (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack_q,
	output logic [31:0] cfg_rdata_q,
	input wire logic preload_valid,
	input wire logic [2:0] preload_cap,
	input wire logic [7:0] preload_link_state,
	input wire logic [15:0] preload_hotplug,
	input wire logic [15:0] preload_link_layer,
	input wire logic [2:0] strap_addr,
	input wire logic pec_fail_evt,
	input wire logic unsup_cmd_evt,
	output logic ctl_pci11_en_q,
	output logic ctl_aspm11_en_q,
	output logic sb_smbus_mode_q,
	output logic [6:0] sb_slave_addr_q,
	output logic sb_pec_check_en_q,
	output logic [1:0] cfc_port_en_q,
	output logic [15:0] cfc_thr_x1_q,
	output logic [15:0] cfc_thr_x2_q
);

	// ==================================================================
	// state of the bank
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic cap_pci11;
		logic cap_aspm11;
		logic cap_l1pm;
		logic ctl_pci11;
		logic ctl_aspm11;
		logic [7:0] link_state;
		logic [15:0] hotplug;
		logic [15:0] link_layer;
		logic sb_proto;
		logic [6:0] sb_addr;
		logic pec_dis;
		logic pec_chk;
		logic [1:0] cfc_en;
		logic [15:0] thr_x1;
		logic [15:0] thr_x2;
		logic strap_done;
	} lss_state_t;

	lss_state_t s_q;
	lss_state_t s_d;
	logic [lss_pkg::NUM_FLAGS-1:0] flag_set;
	logic [lss_pkg::NUM_FLAGS-1:0] flag_clr;
	logic [lss_pkg::NUM_FLAGS-1:0] flag_q;
	logic [31:0] wmask;
	logic wr_hit_sb;

	// ==================================================================
	// decode helpers
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	// byte-enable mask; reserved bits drop out where fields are picked
	assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
	assign wr_hit_sb = cfg_req && cfg_we && hit(cfg_addr, lss_pkg::OFS_SIDEBAND);

	// ==================================================================
	// sticky error flags: bit 0 packet error, bit 1 unsupported command
	// a failure is only counted while checking is enabled
	assign flag_set[0] = pec_fail_evt && !s_q.pec_dis;
	assign flag_set[1] = unsup_cmd_evt;
	assign flag_clr[0] = wr_hit_sb && cfg_be[3] && cfg_wdata[lss_pkg::SB_PEC_FAIL_BIT];
	assign flag_clr[1] = wr_hit_sb && cfg_be[3] && cfg_wdata[lss_pkg::SB_UNSUP_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < lss_pkg::NUM_FLAGS; gi++) begin : g_flag
			lss_flag lss_flag_inst (
				.mclk(mclk),
				.reset_n(reset_n),
				.set(flag_set[gi]),
				.clr(flag_clr[gi]),
				.flag_q(flag_q[gi])
			);
		end
	endgenerate

	// ==================================================================
	// next-state logic: read mux, writes, preload, strap capture
	always_comb begin
		logic [31:0] rd;
		logic [31:0] nw;
		rd = 32'h0000_0000;
		nw = 32'h0000_0000;
		s_d = s_q;
		s_d.ack = cfg_req;
		// read mux; unlisted bits stay zero
		if (hit(cfg_addr, lss_pkg::OFS_CAP_HDR)) begin
			rd = {lss_pkg::CAP_NEXT, lss_pkg::CAP_VER, lss_pkg::CAP_ID};
		end else if (hit(cfg_addr, lss_pkg::OFS_CAP)) begin
			rd[lss_pkg::CAP_PCI11_BIT] = s_q.cap_pci11;
			rd[lss_pkg::CAP_ASPM11_BIT] = s_q.cap_aspm11;
			rd[lss_pkg::CAP_L1PM_BIT] = s_q.cap_l1pm;
		end else if (hit(cfg_addr, lss_pkg::OFS_CTL1)) begin
			rd[lss_pkg::CTL_PCI11_BIT] = s_q.ctl_pci11;
			rd[lss_pkg::CTL_ASPM11_BIT] = s_q.ctl_aspm11;
		end else if (hit(cfg_addr, lss_pkg::OFS_CTL2)) begin
			rd = 32'h0000_0000;
		end else if (hit(cfg_addr, lss_pkg::OFS_LINK_STATE)) begin
			rd[7:0] = s_q.link_state;
		end else if (hit(cfg_addr, lss_pkg::OFS_HOT_LINK)) begin
			rd = {s_q.link_layer, s_q.hotplug};
		end else if (hit(cfg_addr, lss_pkg::OFS_SIDEBAND)) begin
			rd[lss_pkg::SB_PROTO_BIT] = s_q.sb_proto;
			rd[lss_pkg::SB_ADDR_LSB +: 7] = s_q.sb_addr;
			rd[lss_pkg::SB_PEC_DIS_BIT] = s_q.pec_dis;
			rd[lss_pkg::SB_PEC_FAIL_BIT] = flag_q[0];
			rd[lss_pkg::SB_UNSUP_BIT] = flag_q[1];
		end else if (hit(cfg_addr, lss_pkg::OFS_CFC_EN)) begin
			rd[lss_pkg::CFC_P1_BIT] = s_q.cfc_en[0];
			rd[lss_pkg::CFC_P2_BIT] = s_q.cfc_en[1];
		end else if (hit(cfg_addr, lss_pkg::OFS_CFC_THR)) begin
			rd = {s_q.thr_x2, s_q.thr_x1};
		end
		// writes return zero data; unmapped reads return zero as well
		s_d.rdata = (cfg_req && !cfg_we) ? rd : 32'h0000_0000;
		// merged write word; read-only words and reserved bits are never taken
		nw = (rd & ~wmask) | (cfg_wdata & wmask);
		if (cfg_req && cfg_we) begin
			if (hit(cfg_addr, lss_pkg::OFS_CTL1)) begin
				s_d.ctl_pci11 = nw[lss_pkg::CTL_PCI11_BIT];
				s_d.ctl_aspm11 = nw[lss_pkg::CTL_ASPM11_BIT];
			end
			if (hit(cfg_addr, lss_pkg::OFS_SIDEBAND)) begin
				s_d.sb_proto = nw[lss_pkg::SB_PROTO_BIT];
				s_d.sb_addr = nw[lss_pkg::SB_ADDR_LSB +: 7];
				s_d.pec_dis = nw[lss_pkg::SB_PEC_DIS_BIT];
			end
			if (hit(cfg_addr, lss_pkg::OFS_CFC_EN)) begin
				s_d.cfc_en = {nw[lss_pkg::CFC_P2_BIT], nw[lss_pkg::CFC_P1_BIT]};
			end
			if (hit(cfg_addr, lss_pkg::OFS_CFC_THR)) begin
				s_d.thr_x1 = nw[15:0];
				s_d.thr_x2 = nw[31:16];
			end
		end
		// loader replaces read-only defaults; software cannot touch them
		if (preload_valid) begin
			s_d.cap_pci11 = preload_cap[0];
			s_d.cap_aspm11 = preload_cap[1];
			s_d.cap_l1pm = preload_cap[2];
			s_d.link_state = preload_link_state;
			s_d.hotplug = preload_hotplug;
			s_d.link_layer = preload_link_layer;
		end
		// straps are caught on the first edge after reset release
		if (!s_q.strap_done) begin
			s_d.sb_addr[2:0] = strap_addr;
			s_d.strap_done = 1'b1;
		end
		// check-enable kept in its own flop so the output needs no gate
		s_d.pec_chk = !s_d.pec_dis;
	end

	// ==================================================================
	// state register; reset takes constants only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q.ack <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
			s_q.cap_pci11 <= lss_pkg::RST_CAP_PCI11;
			s_q.cap_aspm11 <= lss_pkg::RST_CAP_ASPM11;
			s_q.cap_l1pm <= lss_pkg::RST_CAP_L1PM;
			s_q.ctl_pci11 <= lss_pkg::RST_CTL;
			s_q.ctl_aspm11 <= lss_pkg::RST_CTL;
			s_q.link_state <= lss_pkg::RST_LINK_STATE;
			s_q.hotplug <= lss_pkg::RST_HOTPLUG;
			s_q.link_layer <= lss_pkg::RST_LINK_LAYER;
			s_q.sb_proto <= lss_pkg::RST_SB_PROTO;
			s_q.sb_addr <= {lss_pkg::RST_SB_ADDR_HI, lss_pkg::RST_SB_ADDR_LO};
			s_q.pec_dis <= lss_pkg::RST_PEC_DIS;
			s_q.pec_chk <= !lss_pkg::RST_PEC_DIS;
			s_q.cfc_en <= lss_pkg::RST_CFC_EN;
			s_q.thr_x1 <= lss_pkg::RST_THR_X1;
			s_q.thr_x2 <= lss_pkg::RST_THR_X2;
			s_q.strap_done <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==================================================================
	// outputs, each straight from a flop
	assign cfg_ack_q = s_q.ack;
	assign cfg_rdata_q = s_q.rdata;
	assign ctl_pci11_en_q = s_q.ctl_pci11;
	assign ctl_aspm11_en_q = s_q.ctl_aspm11;
	assign sb_smbus_mode_q = s_q.sb_proto;
	assign sb_slave_addr_q = s_q.sb_addr;
	assign sb_pec_check_en_q = s_q.pec_chk; // own flop, mirrors bit 9 inverted
	assign cfc_port_en_q = s_q.cfc_en;
	assign cfc_thr_x1_q = s_q.thr_x1;
	assign cfc_thr_x2_q = s_q.thr_x2;

	// ==================================================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence rd_of(logic [11:0] ofs);
		cfg_req && !cfg_we && (cfg_addr[11:2] == ofs[11:2]);
	endsequence

	a_hdr_id_ver: assert property (rd_of(lss_pkg::OFS_CAP_HDR) |=>
		cfg_ack_q && cfg_rdata_q[19:0] == 20'h1001E)
		else $error("header id or version wrong");

	a_hdr_next_zero: assert property (rd_of(lss_pkg::OFS_CAP_HDR) |=>
		cfg_rdata_q[31:20] == 12'h000)
		else $error("next capability pointer not zero");

	a_cap_read_only: assert property (!preload_valid |=>
		$stable({s_q.cap_pci11, s_q.cap_aspm11, s_q.cap_l1pm}))
		else $error("capability bit moved without preload");

	a_cap_preload: assert property (preload_valid ##1 rd_of(lss_pkg::OFS_CAP) |=>
		{cfg_rdata_q[4], cfg_rdata_q[3], cfg_rdata_q[1]} == $past(preload_cap, 2))
		else $error("capability preload not visible");

	a_ctl_write: assert property (cfg_req && cfg_we && cfg_be[0] &&
		cfg_addr[11:2] == lss_pkg::OFS_CTL1[11:2] |=>
		ctl_pci11_en_q == $past(cfg_wdata[1]) && ctl_aspm11_en_q == $past(cfg_wdata[3]))
		else $error("control enables not written");

	a_ctl2_zero: assert property (rd_of(lss_pkg::OFS_CTL2) |=> cfg_rdata_q == 32'h0000_0000)
		else $error("control 2 not zero");

	a_proto_write: assert property (cfg_req && cfg_we && cfg_be[0] &&
		cfg_addr[11:2] == lss_pkg::OFS_SIDEBAND[11:2] |=> sb_smbus_mode_q == $past(cfg_wdata[0]))
		else $error("protocol select not written");

	a_strap_catch: assert property ($rose(s_q.strap_done) |->
		sb_slave_addr_q == {4'hD, $past(strap_addr)})
		else $error("strap address not captured");

	a_pec_gate: assert property (pec_fail_evt && !s_q.pec_dis |=> flag_q[0])
		else $error("packet error not flagged");

	a_pec_skip: assert property (s_q.pec_dis && !flag_q[0] && !unsup_cmd_evt |=> !flag_q[0])
		else $error("packet error flagged while checking disabled");

	a_flag_clear: assert property (flag_clr[0] && !flag_set[0] |=> !flag_q[0])
		else $error("packet error flag not cleared");

	a_unsup_set: assert property (unsup_cmd_evt |=> flag_q[1] [*1])
		else $error("unsupported command not flagged");

	a_cfc_enable: assert property (cfg_req && cfg_we && cfg_be[0] &&
		cfg_addr[11:2] == lss_pkg::OFS_CFC_EN[11:2] |=>
		cfc_port_en_q == {$past(cfg_wdata[2]), $past(cfg_wdata[1])})
		else $error("flow enables not written");

	a_thr_write: assert property (cfg_req && cfg_we && cfg_be == 4'hF &&
		cfg_addr[11:2] == lss_pkg::OFS_CFC_THR[11:2] |=>
		{cfc_thr_x2_q, cfc_thr_x1_q} == $past(cfg_wdata))
		else $error("thresholds not written");

	a_rsvd_zero: assert property (rd_of(lss_pkg::OFS_SIDEBAND) |=>
		cfg_rdata_q[31] == 1'b0 && cfg_rdata_q[28:10] == 19'h0 && cfg_rdata_q[8] == 1'b0)
		else $error("reserved sideband bits not zero");

	c_ctl_write: cover property (cfg_req && cfg_we && cfg_addr[11:2] == lss_pkg::OFS_CTL1[11:2]);
	c_pec_fail: cover property ($rose(flag_q[0]));
	c_set_on_clear: cover property (flag_set[1] && flag_clr[1]);
	c_preload: cover property (preload_valid ##1 rd_of(lss_pkg::OFS_CAP));

endmodule

// ---- tb_top.sv ----
/*
 * tb_top: self-checking bench for the substates and sideband register bank.
 * Assumes lss_regs answers every config request with a one-cycle ack on the next edge.
 */
`timescale 1ns/1ps

module tb_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cfg_req = 1'b0;
	logic cfg_we = 1'b0;
	logic [11:0] cfg_addr = 12'h000;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic cfg_ack_q, ctl_pci11_en_q, ctl_aspm11_en_q, sb_smbus_mode_q, sb_pec_check_en_q;
	logic [31:0] cfg_rdata_q;
	logic [6:0] sb_slave_addr_q;
	logic [1:0] cfc_port_en_q;
	logic [15:0] cfc_thr_x1_q, cfc_thr_x2_q;
	logic preload_valid = 1'b0;
	logic [2:0] preload_cap = 3'h0;
	logic [7:0] preload_link_state = 8'h00;
	logic [15:0] preload_hotplug = 16'h0000;
	logic [15:0] preload_link_layer = 16'h0000;
	logic [2:0] strap_addr = 3'h5;
	logic pec_fail_evt = 1'b0;
	logic unsup_cmd_evt = 1'b0;
	int error_cnt = 0;
	int num_checks = 0;
	// shadow copy of every register, kept by the bench alone
	logic [31:0] m_ctl, m_cfc, m_thr, rd;
	logic [9:0] m_sb;
	logic [2:0] m_cap;
	logic [7:0] m_ls;
	logic [15:0] m_hp, m_ll;
	logic [1:0] m_flg;
	logic [11:0] at [10] = '{12'h240, 12'h244, 12'h248, 12'h24C, 12'h33C, 12'h340,
		12'h344, 12'h350, 12'h354, 12'h500};

	lss_regs lss_regs_inst (.mclk(mclk), .reset_n(reset_n), .cfg_req(cfg_req),
		.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q), .preload_valid(preload_valid),
		.preload_cap(preload_cap), .preload_link_state(preload_link_state),
		.preload_hotplug(preload_hotplug), .preload_link_layer(preload_link_layer),
		.strap_addr(strap_addr), .pec_fail_evt(pec_fail_evt), .unsup_cmd_evt(unsup_cmd_evt),
		.ctl_pci11_en_q(ctl_pci11_en_q), .ctl_aspm11_en_q(ctl_aspm11_en_q),
		.sb_smbus_mode_q(sb_smbus_mode_q), .sb_slave_addr_q(sb_slave_addr_q),
		.sb_pec_check_en_q(sb_pec_check_en_q), .cfc_port_en_q(cfc_port_en_q),
		.cfc_thr_x1_q(cfc_thr_x1_q), .cfc_thr_x2_q(cfc_thr_x2_q));

	// ==============================================================
	// clock and watchdog
	always #5 mclk = ~mclk;

	// far beyond the roughly 530 cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		summarize();
	end

	// ==============================================================
	// compares and expectations
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_fld(input logic [15:0] got, input logic [15:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: field %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		case (a)
			12'h240: exp_rd = {12'h000, 4'h1, 16'h001E};
			12'h244: exp_rd = {27'h0, m_cap[2], m_cap[1], 1'b0, m_cap[0], 1'b0};
			12'h248: exp_rd = m_ctl & 32'h0000_000A;
			12'h33C: exp_rd = {24'h0, m_ls};
			12'h340: exp_rd = {m_ll, m_hp};
			12'h344: exp_rd = {1'b0, m_flg, 19'h0, m_sb & 10'h2FF};
			12'h350: exp_rd = m_cfc & 32'h0000_0006;
			12'h354: exp_rd = m_thr;
			default: exp_rd = 32'h0;
		endcase
	endfunction

	// ==============================================================
	// drivers, entered one ns after a rising edge
	task automatic cfg_access(input logic we, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		cfg_req = 1'b1;
		cfg_we = we;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = wd;
		@(posedge mclk);
		#1;
		cfg_req = 1'b0;
		chk_fld({15'h0, cfg_ack_q}, 16'h0001, "ack");
		rd = cfg_rdata_q;
		if (we) begin
			if (a == 12'h248) m_ctl = (m_ctl & ~bm) | (wd & bm);
			if (a == 12'h350) m_cfc = (m_cfc & ~bm) | (wd & bm);
			if (a == 12'h354) m_thr = (m_thr & ~bm) | (wd & bm);
			if (a == 12'h344) m_sb = (m_sb & ~bm[9:0]) | (wd[9:0] & bm[9:0]);
			if (a == 12'h344 && be[3]) m_flg = m_flg & ~wd[30:29];
		end
		// one idle edge so the next request never re-raises req in this step
		@(posedge mclk);
		#1;
	endtask

	task automatic rd_chk(input logic [11:0] a);
		cfg_access(1'b0, a, 4'($urandom), $urandom);
		chk_rd(rd, exp_rd(a), "read");
	endtask

	task automatic chk_fields();
		chk_fld({14'h0, ctl_aspm11_en_q, ctl_pci11_en_q}, {14'h0, m_ctl[3], m_ctl[1]}, "ctl");
		chk_fld({8'h0, sb_slave_addr_q, sb_smbus_mode_q}, {8'h0, m_sb[7:0]}, "sb");
		chk_fld({15'h0, sb_pec_check_en_q}, {15'h0, ~m_sb[9]}, "pec");
		chk_fld({14'h0, cfc_port_en_q}, {14'h0, m_cfc[2:1]}, "cfc");
		chk_fld(cfc_thr_x1_q, m_thr[15:0], "x1");
		chk_fld(cfc_thr_x2_q, m_thr[31:16], "x2");
	endtask

	task automatic pulse(input logic pec, input logic uns);
		pec_fail_evt = pec;
		unsup_cmd_evt = uns;
		@(posedge mclk);
		#1;
		pec_fail_evt = 1'b0;
		unsup_cmd_evt = 1'b0;
		if (pec && !m_sb[9]) m_flg[0] = 1'b1;
		if (uns) m_flg[1] = 1'b1;
		@(posedge mclk);
		#1;
	endtask

	// reset held 16 cycles; straps are caught on the first edge after release
	task automatic do_reset();
		reset_n = 1'b0;
		strap_addr = 3'($urandom);
		repeat (16) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		{m_ctl, m_cfc, m_thr} = {64'h0, 32'h0200_0080};
		m_sb = {2'b10, 4'hD, strap_addr, 1'b1};
		{m_cap, m_ls, m_hp, m_ll, m_flg} = {3'b101, 8'h00, 16'h0000, 16'h0004, 2'b00};
		rd_chk(12'h240);
		rd_chk(12'h244);
		rd_chk(12'h248);
		rd_chk(12'h24C);
		rd_chk(12'h344);
		rd_chk(12'h350);
		rd_chk(12'h354);
		chk_fields();
		$display("test reset done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==============================================================
	// main sequence
	initial begin
		logic [11:0] a;
		void'($urandom(32'h0183));
		do_reset();
		// random reads or writes, each followed after one idle edge by a read of the same word
		repeat (80) begin
			a = at[$urandom_range(9)];
			cfg_access(1'($urandom), a, 4'($urandom), $urandom);
			chk_rd(rd, cfg_we ? 32'h0 : exp_rd(a), "access");
			rd_chk(a);
			chk_fields();
		end
		$display("test random done");
		// preload, then all-ones writes to read-only words must not stick
		repeat (3) begin
			preload_valid = 1'b1;
			{preload_cap, preload_link_state} = 11'($urandom);
			{preload_hotplug, preload_link_layer} = $urandom;
			@(posedge mclk);
			#1;
			preload_valid = 1'b0;
			{m_cap, m_ls, m_hp, m_ll} = {preload_cap, preload_link_state, preload_hotplug,
				preload_link_layer};
			foreach (at[i]) cfg_access(1'b1, at[i], 4'hF, 32'hFFFF_FFFF);
			foreach (at[i]) rd_chk(at[i]);
		end
		$display("test preload done");
		// a failure is ignored while checking is off, caught once it is on
		cfg_access(1'b1, 12'h344, 4'hA, 32'h6000_0200);
		pulse(1'b1, 1'b0);
		rd_chk(12'h344);
		cfg_access(1'b1, 12'h344, 4'h2, 32'h0);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		rd_chk(12'h344);
		cfg_access(1'b1, 12'h344, 4'h8, 32'h2000_0000);
		rd_chk(12'h344);
		// a set in the same cycle as its clear must win
		pec_fail_evt = 1'b1;
		unsup_cmd_evt = 1'b1;
		cfg_access(1'b1, 12'h344, 4'h8, 32'h6000_0000);
		pec_fail_evt = 1'b0;
		unsup_cmd_evt = 1'b0;
		m_flg = 2'b11;
		rd_chk(12'h344);
		cfg_access(1'b1, 12'h344, 4'h7, 32'h6000_0000);
		rd_chk(12'h344);
		$display("test events done");
		do_reset();
		summarize();
	end
endmodule
